// ===== verilog/adcp_map.vh
/*
 adcp_map.vh: register offsets, field positions, reset values and timing
 counts for the converter post-processing control block.
 assumes it is included by bare name into the block's module file.
*/
`ifndef ADCP_MAP_VH
`define ADCP_MAP_VH

// register offsets on the 8-bit configuration write port
`define ADCP_A_SWING 8'h01
`define ADCP_A_PERF1 8'h03
`define ADCP_A_STRENGTH 8'h26
`define ADCP_A_FORMAT 8'h3d
`define ADCP_A_IFSEL 8'h41
`define ADCP_A_LATPWR 8'h42
`define ADCP_A_PDN 8'h43
`define ADCP_A_PERF2 8'h4a
`define ADCP_A_TRIM 8'hcf
`define ADCP_A_STATUS 8'hf0

// reset value of every register
`define ADCP_RST_VAL 8'h00

// field positions
`define ADCP_B_TRIM_EN 5
`define ADCP_B_BYPASS_OFF 3
`define ADCP_B_CORE_SLEEP 2
`define ADCP_B_FULL_SLEEP 6
`define ADCP_B_OUTBUF_OFF 4
`define ADCP_B_HOLD 7

// field codes
`define ADCP_FMT_OFFBIN 2'b10
`define ADCP_IF_CMOS 2'b11
`define ADCP_PERF_ON 2'b11
`define ADCP_SWING_EN 2'b11
`define ADCP_TC_LAST 4'hb
`define ADCP_TC_BASE 6'h14

// four-level pin codes: ground, 3/8, 5/8, full supply
`define ADCP_LVL_GND 2'b00
`define ADCP_LVL_3_8 2'b01
`define ADCP_LVL_5_8 2'b10
`define ADCP_LVL_FULL 2'b11

// datapath figures
`define ADCP_BYPASS_LAT 10
`define ADCP_POS_FS 14'h1fff
`define ADCP_NEG_FS 14'h2000

// times in ns and derived cycle counts at the 40 ns core clock
`define ADCP_CLK_NS 40
`define ADCP_T_GPD_NS 100000
`define ADCP_T_CORE_SLEEP_NS 5000
`define ADCP_T_OBUF_NS 100
`define ADCP_T_SLOW_NS 1000
// the times above in core cycles, rounded up, sized to their counters
`define ADCP_GPD_CYC 12'h9c4
`define ADCP_CORE_SLEEP_CYC 12'h07d
`define ADCP_OBUF_CYC 2'h3
`define ADCP_SLOW_CYC 5'h19

`endif

// ===== verilog/adcp_postproc.v
/*
 adcp_postproc.v: post-processing and output control behind a pipelined
 converter core: offset loop, coding, power modes, DDR LVDS / CMOS output.
 assumes core_clk is a free-running 25 MHz clock, the sampling clock arrives
 as a pin and is sampled here, and the converter words come on core_clk.
*/
// What this block does
// - when enabled, estimate dc offset and subtract it from each sample.
// - four-bit code picks loop constant, 1M cycles doubling to 2G, 12-15 reserved.
// - hold bit freezes the estimate and keeps applying the last one.
// - after reset: low-latency bypass, offset correction off.
// - full sleep stops everything, buffers off, valid data after 100 us.
// - core sleep stops only conversion, valid data after 5 us.
// - buffers off by register bit or enable pin, back after 100 ns.
// - enter low-power state when the sampling clock is below 1 MSPS.
// - twos complement or offset binary, from register or configuration pin.
// - overdrive forces full-scale code in the overdrive direction.
// - output is DDR LVDS or parallel CMOS, from register or pin.
// - LVDS pairs carry even bits at falling, odd bits at rising clock.
// - LVDS swing defaults to 350 mV, programmable 125 to 570 mV.
// - double-strength buffer selectable separately for data and clock.
// - CMOS gives every bit its own pin once per sample, with clock.
// - performance settings only by serial writes, not in pin mode.
// - pin levels: gnd 2c/LVDS, 3/8 2c/CMOS, 5/8 ob/CMOS, full ob/LVDS.
// - bypass mode passes raw words with 10 cycles latency.
// - post-processing acts only once bypass-off is written to one.
`timescale 1ns/1ps
`include "adcp_map.vh"

module adcp_postproc
(
   // clock and reset
   input wire core_clk,
   input wire rst,
   // pins from outside the clock domain
   input wire samp_clk_pin,
   input wire out_enable_pin,
   input wire pin_cfg_mode,
   input wire [1:0] four_level_cfg_pin,
   input wire rx_stall,
   // converter core words, on core_clk
   input wire [13:0] adc_word,
   input wire adc_ovr_pos,
   input wire adc_ovr_neg,
   // register port
   input wire reg_wr_en,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wr_data,
   output reg [7:0] reg_rd_data,
   // output interface
   output wire pipe_ready,
   output reg [13:0] cmos_data,
   output reg cmos_oe,
   output reg out_clock,
   output reg [6:0] lvds_pair_data,
   output reg lvds_oe,
   output reg out_clock_pos,
   // buffer and power controls
   output reg [5:0] lvds_swing_code,
   output reg data_drive_double,
   output reg clk_drive_double,
   output reg perf_mode1_on,
   output reg perf_mode2_on,
   output reg core_powered,
   output reg refs_powered,
   output reg low_power_state,
   output reg data_valid
);

   // two-flop synchronisers; stage one feeds stage two only
   reg [5:0] sync1_r;
   reg [5:0] sync2_r;
   reg samp_d_r;
   wire samp_s = sync2_r[0];
   wire oe_s = sync2_r[1];
   wire par_s = sync2_r[2];
   wire [1:0] lvl_s = sync2_r[4:3];
   wire stall_s = sync2_r[5];
   wire samp_rise = samp_s & ~samp_d_r;
   wire samp_fall = ~samp_s & samp_d_r;

   always @(posedge core_clk)
   begin
      sync1_r <= {rx_stall, four_level_cfg_pin, pin_cfg_mode, out_enable_pin, samp_clk_pin};
      sync2_r <= sync1_r;
      samp_d_r <= samp_s;
   end

   // configuration registers
   reg [5:0] swing_r;
   reg [1:0] perf1_r;
   reg [1:0] strength_r;
   reg [1:0] fmt_r;
   reg trim_en_r;
   reg [1:0] ifsel_r;
   reg bypass_off_r;
   reg core_sleep_r;
   reg full_sleep_r;
   reg outbuf_off_r;
   reg [1:0] swing_en_r;
   reg perf2_r;
   reg hold_r;
   reg [3:0] tc_r;

   // all fields clear at reset, so bypass on and trim off
   // pin configuration mode ignores every register write
   always @(posedge core_clk)
   begin
      if (rst || par_s)
      begin
         swing_r <= 6'h00;
         perf1_r <= 2'h0;
         strength_r <= 2'h0;
         fmt_r <= 2'h0;
         trim_en_r <= 1'b0;
         ifsel_r <= 2'h0;
         bypass_off_r <= 1'b0;
         core_sleep_r <= 1'b0;
         full_sleep_r <= 1'b0;
         outbuf_off_r <= 1'b0;
         swing_en_r <= 2'h0;
         perf2_r <= 1'b0;
         hold_r <= 1'b0;
         tc_r <= 4'h0;
      end
      else if (reg_wr_en)
      begin
         case (reg_addr)
            `ADCP_A_SWING: swing_r <= reg_wr_data[7:2];
            `ADCP_A_PERF1: perf1_r <= reg_wr_data[1:0];
            `ADCP_A_STRENGTH: strength_r <= reg_wr_data[1:0];
            `ADCP_A_FORMAT:
            begin
               fmt_r <= reg_wr_data[7:6];
               trim_en_r <= reg_wr_data[`ADCP_B_TRIM_EN];
            end
            `ADCP_A_IFSEL: ifsel_r <= reg_wr_data[7:6];
            `ADCP_A_LATPWR:
            begin
               bypass_off_r <= reg_wr_data[`ADCP_B_BYPASS_OFF];
               core_sleep_r <= reg_wr_data[`ADCP_B_CORE_SLEEP];
            end
            `ADCP_A_PDN:
            begin
               full_sleep_r <= reg_wr_data[`ADCP_B_FULL_SLEEP];
               outbuf_off_r <= reg_wr_data[`ADCP_B_OUTBUF_OFF];
               swing_en_r <= reg_wr_data[1:0];
            end
            `ADCP_A_PERF2: perf2_r <= reg_wr_data[0];
            `ADCP_A_TRIM:
            begin
               hold_r <= reg_wr_data[`ADCP_B_HOLD];
               tc_r <= reg_wr_data[5:2];
            end
            default: ;
         endcase
      end
   end

   // coding from register, or from the pin in pin mode
   // four-level pin decode of coding and interface
   wire ob_sel = par_s ? (lvl_s == `ADCP_LVL_5_8 || lvl_s == `ADCP_LVL_FULL) : (fmt_r == `ADCP_FMT_OFFBIN);
   // interface from register, or from the pin in pin mode
   wire cmos_sel = par_s ? (lvl_s == `ADCP_LVL_3_8 || lvl_s == `ADCP_LVL_5_8) : (ifsel_r == `ADCP_IF_CMOS);

   // sample steps only while awake; a full buffer also stalls the pipe
   wire fifo_ready;
   wire step = samp_rise & ~full_sleep_r & ~core_sleep_r & fifo_ready;

   // ten-stage raw delay line, one stage per sample
   reg [15:0] dl_r [0:`ADCP_BYPASS_LAT-1];
   always @(posedge core_clk)
   begin
      if (step)
         dl_r[0] <= {adc_ovr_pos, adc_ovr_neg, adc_word};
   end
   genvar gi;
   generate
      for (gi = 1; gi < `ADCP_BYPASS_LAT; gi = gi + 1)
      begin : g_dl
         always @(posedge core_clk)
         begin
            if (step)
               dl_r[gi] <= dl_r[gi-1];
         end
      end
   endgenerate
   wire [15:0] tail = dl_r[`ADCP_BYPASS_LAT-1];

   // processing only once bypass is switched off
   wire trim_active = bypass_off_r & trim_en_r;
   // reserved codes leave the estimate untouched
   wire tc_ok = (tc_r <= `ADCP_TC_LAST);
   wire [5:0] shamt = `ADCP_TC_BASE + {2'b00, tc_r};
   reg signed [47:0] acc_r;
   wire signed [47:0] est = acc_r >>> shamt;
   wire signed [47:0] samp_x = {{34{tail[13]}}, tail[13:0]};

   // first-order accumulator, gain set by the shift
   // hold stops the update while the estimate stays applied
   always @(posedge core_clk)
   begin
      if (rst || !trim_active)
         acc_r <= 48'sh0000_0000_0000;
      else if (step && !hold_r && tc_ok)
         acc_r <= acc_r + samp_x - est;
   end

   // subtract the current estimate, saturated to 14 bits
   wire signed [16:0] corr = samp_x[16:0] - est[16:0];
   reg [13:0] corr_sat;
   always @*
   begin
      corr_sat = corr[13:0];
      if (corr > 17'sh0_1fff)
         corr_sat = `ADCP_POS_FS;
      else if (corr < -17'sh0_2000)
         corr_sat = `ADCP_NEG_FS;
   end

   // processed word takes one stage beyond the bypass path
   reg [15:0] proc_r;
   reg word_vld_r;
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         proc_r <= 16'h0000;
         word_vld_r <= 1'b0;
      end
      else
      begin
         word_vld_r <= step;
         if (step)
            proc_r <= {tail[15:14], trim_active ? corr_sat : tail[13:0]};
      end
   end

   // overdrive forces the full-scale code, then coding applies
   wire [15:0] sel_w = bypass_off_r ? proc_r : tail;
   reg [13:0] coded;
   always @*
   begin
      coded = sel_w[13:0];
      if (sel_w[15])
         coded = `ADCP_POS_FS;
      else if (sel_w[14])
         coded = `ADCP_NEG_FS;
      if (ob_sel)
         coded = {~coded[13], coded[12:0]};
   end

   // two-entry buffer; a stalled receiver backs up into the pipe
   reg [13:0] fifo_r [0:1];
   reg wp_r;
   reg rp_r;
   reg [1:0] cnt_r;
   assign fifo_ready = (cnt_r != 2'd2);
   assign pipe_ready = fifo_ready;
   wire push = word_vld_r & fifo_ready;
   wire pop = samp_fall & ~stall_s & (cnt_r != 2'd0);
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'd0;
      end
      else
      begin
         if (push)
         begin
            fifo_r[wp_r] <= coded;
            wp_r <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         if (push && !pop)
            cnt_r <= cnt_r + 2'd1;
         else if (pop && !push)
            cnt_r <= cnt_r - 2'd1;
      end
   end

   // power sequencing: wake timers after sleep exits
   reg full_d_r;
   reg core_d_r;
   reg [11:0] wake_r;
   reg [1:0] obuf_wait_r;
   wire buf_req_off = outbuf_off_r | ~oe_s | full_sleep_r;
   // core cycles since last sampling rise, saturating
   reg [4:0] gap_r;
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         full_d_r <= 1'b0;
         core_d_r <= 1'b0;
         wake_r <= 12'h000;
         obuf_wait_r <= 2'h0;
         gap_r <= 5'h00;
         low_power_state <= 1'b0;
      end
      else
      begin
         full_d_r <= full_sleep_r;
         core_d_r <= core_sleep_r;
         // full sleep exit waits 100 us for valid data
         if (full_d_r && !full_sleep_r)
            wake_r <= `ADCP_GPD_CYC;
         // core sleep exit waits 5 us
         else if (core_d_r && !core_sleep_r)
            wake_r <= `ADCP_CORE_SLEEP_CYC;
         else if (wake_r != 12'h000)
            wake_r <= wake_r - 12'h001;
         // buffers come back 100 ns after the request clears
         if (buf_req_off)
            obuf_wait_r <= `ADCP_OBUF_CYC;
         else if (obuf_wait_r != 2'h0)
            obuf_wait_r <= obuf_wait_r - 2'h1;
         if (samp_rise)
            gap_r <= 5'h00;
         else if (gap_r <= `ADCP_SLOW_CYC)
            gap_r <= gap_r + 5'h01;
         // longer than 1 us between rises means below 1 MSPS
         low_power_state <= (gap_r > `ADCP_SLOW_CYC);
      end
   end
   wire buf_on = ~buf_req_off & (obuf_wait_r == 2'h0);

   // output stage: new word at falling edge, even bits with it
   reg [13:0] word_r;
   wire [13:0] head = fifo_r[rp_r];
   wire [13:0] word_sel = pop ? head : word_r;
   integer k;
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         word_r <= 14'h0000;
         lvds_pair_data <= 7'h00;
         cmos_data <= 14'h0000;
      end
      else
      begin
         if (pop)
            word_r <= head;
         // every bit on its own pin, refreshed once per sample
         // data settles at falling edge, stable for rising capture
         if (samp_fall)
            cmos_data <= buf_on ? word_sel : 14'h0000;
         // even bits at falling edge, odd bits at rising edge
         for (k = 0; k < 7; k = k + 1)
         begin
            if (samp_fall)
               lvds_pair_data[k] <= buf_on & word_sel[2*k];
            else if (samp_rise)
               lvds_pair_data[k] <= buf_on & word_r[2*k+1];
         end
      end
   end

   // output clocks, enables and buffer controls
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         out_clock <= 1'b0;
         out_clock_pos <= 1'b0;
         cmos_oe <= 1'b0;
         lvds_oe <= 1'b0;
         lvds_swing_code <= 6'h00;
         data_drive_double <= 1'b0;
         clk_drive_double <= 1'b0;
         perf_mode1_on <= 1'b0;
         perf_mode2_on <= 1'b0;
         core_powered <= 1'b0;
         refs_powered <= 1'b0;
         data_valid <= 1'b0;
      end
      else
      begin
         out_clock <= samp_s & buf_on & cmos_sel;
         out_clock_pos <= samp_s & buf_on & ~cmos_sel;
         // full sleep leaves both buffer sets high-impedance
         // register bit or pin disables the buffers
         cmos_oe <= buf_on & cmos_sel;
         lvds_oe <= buf_on & ~cmos_sel;
         // zero code means 350 mV; swing control needs its enable
         lvds_swing_code <= (swing_en_r == `ADCP_SWING_EN) ? swing_r : 6'h00;
         // separate double-strength for data and clock buffers
         data_drive_double <= strength_r[0];
         clk_drive_double <= strength_r[1];
         perf_mode1_on <= (perf1_r == `ADCP_PERF_ON);
         perf_mode2_on <= perf2_r;
         // core sleep keeps the references running
         // same term as low_power_state, so the two never disagree for a cycle
         core_powered <= ~full_sleep_r & ~core_sleep_r & (gap_r <= `ADCP_SLOW_CYC);
         refs_powered <= ~full_sleep_r;
         data_valid <= buf_on & ~core_sleep_r & (wake_r == 12'h000);
      end
   end

   // registered read-back, status at its own offset
   always @(posedge core_clk)
   begin
      if (rst)
         reg_rd_data <= 8'h00;
      else
      begin
         case (reg_addr)
            `ADCP_A_SWING: reg_rd_data <= {swing_r, 2'b00};
            `ADCP_A_PERF1: reg_rd_data <= {6'h00, perf1_r};
            `ADCP_A_STRENGTH: reg_rd_data <= {6'h00, strength_r};
            `ADCP_A_FORMAT: reg_rd_data <= {fmt_r, trim_en_r, 5'h00};
            `ADCP_A_IFSEL: reg_rd_data <= {ifsel_r, 6'h00};
            `ADCP_A_LATPWR: reg_rd_data <= {4'h0, bypass_off_r, core_sleep_r, 2'b00};
            `ADCP_A_PDN: reg_rd_data <= {1'b0, full_sleep_r, 1'b0, outbuf_off_r, 2'b00, swing_en_r};
            `ADCP_A_PERF2: reg_rd_data <= {7'h00, perf2_r};
            `ADCP_A_TRIM: reg_rd_data <= {hold_r, 1'b0, tc_r, 2'b00};
            `ADCP_A_STATUS: reg_rd_data <= {3'h0, par_s, cnt_r, (wake_r != 12'h000), low_power_state};
            default: reg_rd_data <= 8'h00;
         endcase
      end
   end

endmodule // adcp_postproc

// ===== bench/adcp_postproc_sva.sv
/*
 adcp_postproc_sva.sv: port checks for the post-processing block.
 assumes a 40 ns core_clk and a synchronous active-high rst.
*/
`timescale 1ns/1ps
module adcp_postproc_sva
(
   // clock and reset
   input wire core_clk,
   input wire rst,
   // watched pins
   input wire samp_clk_pin,
   input wire pin_cfg_mode,
   // watched outputs
   input wire [13:0] cmos_data,
   input wire cmos_oe,
   input wire out_clock,
   input wire [6:0] lvds_pair_data,
   input wire lvds_oe,
   input wire out_clock_pos,
   input wire [5:0] lvds_swing_code,
   input wire perf_mode1_on,
   input wire perf_mode2_on,
   input wire core_powered,
   input wire refs_powered,
   input wire low_power_state,
   input wire data_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   reg [5:0] gap_r;
   reg samp_q_r;
   // cycles since the last sampling rise, saturating so it never wraps
   always @(posedge core_clk)
   begin
      samp_q_r <= samp_clk_pin;
      if (rst || (samp_clk_pin && !samp_q_r))
         gap_r <= 6'h00;
      else if (gap_r != 6'h3f)
         gap_r <= gap_r + 6'h01;
   end
   property p_rst_quiet;
      $fell(rst) |-> !cmos_oe && !lvds_oe && !data_valid && lvds_swing_code == 6'h00;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active at reset release");
   property p_one_if;
      !(cmos_oe && lvds_oe);
   endproperty
   a_one_if: assert property (p_one_if) else $error("both interfaces driven");
   property p_one_clk;
      !(out_clock && out_clock_pos);
   endproperty
   a_one_clk: assert property (p_one_clk) else $error("both output clocks high");
   property p_cmos_hold;
      $rose(out_clock) |-> $stable(cmos_data);
   endproperty
   a_cmos_hold: assert property (p_cmos_hold) else $error("cmos word moved at clock rise");
   property p_pair_hold;
      lvds_oe && $past(lvds_oe) && out_clock_pos && $past(out_clock_pos) |-> $stable(lvds_pair_data);
   endproperty
   a_pair_hold: assert property (p_pair_hold) else $error("odd bits moved while clock high");
   property p_sleep;
      !refs_powered |-> !core_powered && !data_valid;
   endproperty
   a_sleep: assert property (p_sleep) else $error("core alive with references off");
   property p_lp_core;
      low_power_state |-> !core_powered;
   endproperty
   a_lp_core: assert property (p_lp_core) else $error("core powered in low-power state");
   property p_lp_exit;
      gap_r >= 6'd10 && gap_r <= 6'd20 |-> !low_power_state;
   endproperty
   a_lp_exit: assert property (p_lp_exit) else $error("low power with clock running");
   property p_lp_enter;
      gap_r >= 6'd40 |-> low_power_state;
   endproperty
   a_lp_enter: assert property (p_lp_enter) else $error("no low power after clock stop");
   property p_valid_buf;
      data_valid |-> cmos_oe || lvds_oe;
   endproperty
   a_valid_buf: assert property (p_valid_buf) else $error("valid with buffers off");
   property p_pin_perf;
      pin_cfg_mode [*8] |-> !perf_mode1_on && !perf_mode2_on;
   endproperty
   a_pin_perf: assert property (p_pin_perf) else $error("tuning active in pin mode");
   // main scenarios reached
   c_lp: cover property ($rose(low_power_state));
   c_cmos: cover property ($rose(cmos_oe));
   c_sleep: cover property ($fell(refs_powered));
endmodule // adcp_postproc_sva

bind adcp_postproc adcp_postproc_sva u_sva (.core_clk(core_clk), .rst(rst), .samp_clk_pin(samp_clk_pin),
   .pin_cfg_mode(pin_cfg_mode), .cmos_data(cmos_data), .cmos_oe(cmos_oe), .out_clock(out_clock),
   .lvds_pair_data(lvds_pair_data), .lvds_oe(lvds_oe), .out_clock_pos(out_clock_pos),
   .lvds_swing_code(lvds_swing_code), .perf_mode1_on(perf_mode1_on), .perf_mode2_on(perf_mode2_on),
   .core_powered(core_powered), .refs_powered(refs_powered), .low_power_state(low_power_state),
   .data_valid(data_valid));

// ===== bench/adcp_rx_model.sv
/*
 adcp_rx_model.sv: capture receiver on the block's output pins.
 assumes the output clocks are slow against core_clk, so edges are found by sampling.
*/
`timescale 1ns/1ps
module adcp_rx_model
(
   // clock and reset
   input wire core_clk,
   input wire rst,
   // output pins of the block
   input wire out_clock,
   input wire out_clock_pos,
   input wire [13:0] cmos_data,
   input wire cmos_oe,
   input wire [6:0] lvds_pair_data,
   input wire lvds_oe,
   // stall control and result
   input wire stall_req,
   output wire rx_stall,
   output reg [13:0] rx_word
);
   reg oc_q_r;
   reg op_q_r;
   reg [6:0] even_r;
   integer k;
   assign rx_stall = stall_req;
   // edge capture, one cycle after each clock edge so data has settled
   always @(posedge core_clk)
   begin
      oc_q_r <= out_clock;
      op_q_r <= out_clock_pos;
      if (rst)
         rx_word <= 14'h0000;
      if (!rst && cmos_oe && out_clock && !oc_q_r)
         rx_word <= cmos_data;
      if (lvds_oe && !out_clock_pos && op_q_r)
         even_r <= lvds_pair_data;
      if (!rst && lvds_oe && out_clock_pos && !op_q_r)
         for (k = 0; k < 7; k = k + 1)
         begin
            rx_word[2*k] <= even_r[k];
            rx_word[2*k+1] <= lvds_pair_data[k];
         end
   end
endmodule // adcp_rx_model

// ===== bench/adc_output_postproc_control_tb.sv
/*
 adc_output_postproc_control_tb.sv: self-checking bench for adcp_postproc.
 assumes the block as instantiated below and the receiver model beside it.
*/
`timescale 1ns/1ps
module adc_output_postproc_control_tb;
   logic core_clk = 0, rst = 1, samp_clk_pin = 0, samp_run = 1, out_enable_pin = 1, pin_cfg_mode = 0;
   logic [1:0] four_level_cfg_pin = 2'b00;
   logic stall_req = 0, adc_ovr_pos = 0, adc_ovr_neg = 0, reg_wr_en = 0;
   logic [13:0] adc_word = 14'h0123;
   logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00;
   wire [7:0] reg_rd_data;
   wire [13:0] cmos_data, rx_word;
   wire [6:0] lvds_pair_data;
   wire [5:0] lvds_swing_code;
   wire pipe_ready, cmos_oe, out_clock, lvds_oe, out_clock_pos, data_drive_double, clk_drive_double;
   wire perf_mode1_on, perf_mode2_on, core_powered, refs_powered, low_power_state, data_valid, rx_stall;
   int bad_count = 0, check_count = 0, cyc_count = 0, i;
   // address, write data, read-back expected; last row is unmapped
   logic [23:0] rows [0:9] = '{24'h01_fcfc, 24'h03_0303, 24'h26_0303, 24'h3d_8080, 24'h41_c0c0,
      24'h42_0808, 24'h43_1313, 24'h4a_0101, 24'hcf_acac, 24'h77_5a00};
   always #20 core_clk = ~core_clk;
   // sampling clock, phase offset from core_clk, can be stopped
   initial
   begin
      #7;
      forever #160 if (samp_run) samp_clk_pin = ~samp_clk_pin;
   end
   adcp_postproc uut (.core_clk(core_clk), .rst(rst), .samp_clk_pin(samp_clk_pin),
      .out_enable_pin(out_enable_pin), .pin_cfg_mode(pin_cfg_mode), .four_level_cfg_pin(four_level_cfg_pin),
      .rx_stall(rx_stall), .adc_word(adc_word), .adc_ovr_pos(adc_ovr_pos), .adc_ovr_neg(adc_ovr_neg),
      .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
      .pipe_ready(pipe_ready), .cmos_data(cmos_data), .cmos_oe(cmos_oe), .out_clock(out_clock),
      .lvds_pair_data(lvds_pair_data), .lvds_oe(lvds_oe), .out_clock_pos(out_clock_pos),
      .lvds_swing_code(lvds_swing_code), .data_drive_double(data_drive_double),
      .clk_drive_double(clk_drive_double), .perf_mode1_on(perf_mode1_on), .perf_mode2_on(perf_mode2_on),
      .core_powered(core_powered), .refs_powered(refs_powered), .low_power_state(low_power_state),
      .data_valid(data_valid));
   adcp_rx_model u_rx (.core_clk(core_clk), .rst(rst), .out_clock(out_clock), .out_clock_pos(out_clock_pos),
      .cmos_data(cmos_data), .cmos_oe(cmos_oe), .lvds_pair_data(lvds_pair_data), .lvds_oe(lvds_oe),
      .stall_req(stall_req), .rx_stall(rx_stall), .rx_word(rx_word));
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [13:0] g, input logic [13:0] e);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error at %0t: word %h expected %h", $time, g, e);
      end
   endtask
   task chk_b(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error at %0t: flag %b expected %b", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   // one-cycle write strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge core_clk);
      reg_wr_en <= 1'b0;
   endtask
   // read data stands one cycle after the address
   task rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] g;
      @(posedge core_clk);
      reg_addr <= a;
      @(posedge core_clk);
      @(negedge core_clk);
      g = reg_rd_data;
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error at %0t: read %h expected %h", $time, g, e);
      end
   endtask
   // cut a hang short
   always @(posedge core_clk)
   begin
      cyc_count++;
      if (cyc_count == 30000)
      begin
         bad_count++;
         complete_run;
      end
   end
   initial
   begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      cyc(4);
      for (i = 0; i < 10; i++) rd(rows[i][23:16], 8'h00);
      chk_b(perf_mode1_on, 1'b0);
      for (i = 0; i < 10; i++)
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      cyc(5);
      chk_b(perf_mode1_on, 1'b1);
      chk_b(perf_mode2_on, 1'b1);
      chk_b(data_drive_double & clk_drive_double, 1'b1);
      chk({8'h00, lvds_swing_code}, 14'h003f);
      chk_b(cmos_oe | lvds_oe, 1'b0);
      for (i = 0; i < 10; i++) wr(rows[i][23:16], 8'h00);
      wr(8'h26, 8'h02);
      cyc(3);
      chk_b(data_drive_double, 1'b0);
      chk_b(clk_drive_double, 1'b1);
      wr(8'h26, 8'h00);
      cyc(200);
      chk(rx_word, 14'h0123);
      wr(8'h41, 8'hc0);
      cyc(200);
      chk(rx_word, 14'h0123);
      chk_b(cmos_oe, 1'b1);
      wr(8'h42, 8'h08);
      wr(8'h3d, 8'h80);
      cyc(200);
      chk(rx_word, 14'h2123);
      @(posedge core_clk) adc_ovr_pos <= 1'b1;
      cyc(200);
      chk(rx_word, 14'h3fff);
      @(posedge core_clk) {adc_ovr_pos, adc_ovr_neg} <= 2'b01;
      cyc(200);
      chk(rx_word, 14'h0000);
      wr(8'h3d, 8'h00);
      cyc(200);
      chk(rx_word, 14'h2000);
      @(posedge core_clk) adc_ovr_neg <= 1'b0;
      cyc(200);
      @(posedge core_clk) stall_req <= 1'b1;
      cyc(40);
      @(posedge core_clk) adc_word <= 14'h1abc;
      cyc(200);
      chk(rx_word, 14'h0123);
      chk_b(pipe_ready, 1'b0);
      @(posedge core_clk) stall_req <= 1'b0;
      cyc(200);
      chk(rx_word, 14'h1abc);
      @(posedge core_clk) out_enable_pin <= 1'b0;
      cyc(10);
      chk_b(cmos_oe | data_valid, 1'b0);
      @(posedge core_clk) out_enable_pin <= 1'b1;
      cyc(10);
      chk_b(cmos_oe, 1'b1);
      wr(8'h43, 8'h40);
      cyc(10);
      chk_b(refs_powered | core_powered | cmos_oe, 1'b0);
      wr(8'h43, 8'h00);
      cyc(1000);
      chk_b(data_valid, 1'b0);
      cyc(1700);
      chk_b(data_valid, 1'b1);
      wr(8'h42, 8'h0c);
      cyc(10);
      chk_b(core_powered, 1'b0);
      chk_b(refs_powered, 1'b1);
      wr(8'h42, 8'h08);
      cyc(100);
      chk_b(data_valid, 1'b0);
      cyc(60);
      chk_b(data_valid, 1'b1);
      samp_run = 0;
      cyc(80);
      chk_b(low_power_state, 1'b1);
      samp_run = 1;
      cyc(40);
      chk_b(low_power_state, 1'b0);
      wr(8'h03, 8'h03);
      cyc(3);
      chk_b(perf_mode1_on, 1'b1);
      @(posedge core_clk) pin_cfg_mode <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         @(posedge core_clk) four_level_cfg_pin <= i[1:0];
         cyc(200);
         chk_b(cmos_oe, i == 1 || i == 2);
         chk(rx_word, (i < 2) ? 14'h1abc : 14'h3abc);
      end
      wr(8'h03, 8'h03);
      cyc(5);
      chk_b(perf_mode1_on, 1'b0);
      rd(8'h03, 8'h00);
      complete_run;
   end
endmodule // adc_output_postproc_control_tb
